// [rtl/umg_pkg.sv]
// Package with constants for the usage meter and on-line gating block
package umg_pkg;
	localparam int NUM_UNITS = 6;
	localparam int CLK_MHZ = 250;
	localparam int DEBOUNCE_US = 10;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
	localparam int DEB_W = 12;
	localparam int WB_AW = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_UNITS = 4'h8;
	localparam int CTRL_OPBUSY_BIT = 0;
	localparam int CTRL_INTLK_BIT = 1;
	localparam int CTRL_PWR_BIT = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
	localparam int ST_ONLINE_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_RUN_BIT = 2;
	localparam int ST_MIN_BIT = 3;
	localparam int ST_MSW_BIT = 4;
	localparam int ST_CSW_BIT = 5;
endpackage : umg_pkg

// [rtl/umg_deb_if.sv]
// Interface carrying one switch through the debouncer
`timescale 1ns/10ps
interface umg_deb_if;
	logic raw;
	logic clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface : umg_deb_if

// [rtl/umg_debounce.sv]
// Two-flop synchroniser followed by a stability counter
`timescale 1ns/10ps
module umg_debounce #(
	parameter int COUNT = umg_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Switch path
	umg_deb_if.filt sw
);
	logic sync1_q;
	logic sync2_q;
	logic clean_q;
	// Terminal count, cut to the counter width on purpose
	localparam int LAST_I = COUNT - 1;
	localparam logic [umg_pkg::DEB_W-1:0] LAST = LAST_I[umg_pkg::DEB_W-1:0];

	logic [umg_pkg::DEB_W-1:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= sw.raw;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			clean_q <= 1'b0;
		end
		else if (sync2_q == clean_q)
			cnt_q <= '0;
		else if (cnt_q == LAST)
		begin
			cnt_q <= '0;
			clean_q <= sync2_q;
		end
		else
			cnt_q <= cnt_q + 1'b1;
	end

	assign sw.clean = clean_q;
endmodule : umg_debounce

// [rtl/umg_top.sv]
// Usage meter, on-line latch, metering lines and select bypass
`timescale 1ns/10ps
// Contract
// - The meter runs only when on-line, meter-out active and a unit is loaded and either off its marker or rewinding.
// - The on-line latch changes only while clock-out is inactive and the block is idle.
// - Meter-in to the channel is active only while on-line and busy.
// - Busy means the command-busy latch is set, from an operation or a channel interlock.
// - Meter-out is accepted only when on-line; off-line blocks meter-out, meter-in and meter.
// - A loaded unit off its beginning marker counts as in use without tape motion.
// - Turning the command switch off its on-line position clears the on-line latch once clock-out is inactive and the block is idle.
// - The latch sets only when meter switch is on and command switch at on-line together.
// - No on-line operation is permitted while the latch is clear.
// - Select passes to the next unit when command switch off, meter switch off or power off.
// - All channel interface lines except SELECT_BYPASS are forced inactive while the latch is clear; SELECT_BYPASS passes select.
module umg_top #(
	parameter int UNITS = umg_pkg::NUM_UNITS,
	parameter int DEB_COUNT = umg_pkg::DEBOUNCE_CYCLES
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [umg_pkg::WB_AW-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Panel switches
	input wire logic METER_SW,
	input wire logic CMD_SW_ONLINE,
	// Drive unit status
	input wire logic [UNITS-1:0] UNIT_LOADED,
	input wire logic [UNITS-1:0] UNIT_AT_MARKER,
	input wire logic [UNITS-1:0] UNIT_REWINDING,
	// Metering lines
	input wire logic METER_OUT,
	input wire logic CLOCK_OUT,
	output logic METER_IN,
	output logic RUN_METER,
	// Select routing and interface gating
	input wire logic SELECT_IN,
	output logic SELECT_TO_UNIT,
	output logic SELECT_BYPASS,
	output logic IF_ENABLE
);
	logic online_q;
	logic [31:0] ctrl_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic meter_sw_db;
	logic cmd_sw_db;
	logic busy;
	logic meter_out_g;
	logic [UNITS-1:0] unit_meter_on;
	logic any_meter_on;
	logic change_ok;
	logic power_on;
	logic wb_req;

	umg_deb_if msw_if();
	umg_deb_if csw_if();
	assign msw_if.raw = METER_SW;
	assign csw_if.raw = CMD_SW_ONLINE;

	umg_debounce #(.COUNT(DEB_COUNT)) u_deb_msw (
		.clk(MCLK),
		.rst_n(RST_N),
		.sw(msw_if)
	);
	umg_debounce #(.COUNT(DEB_COUNT)) u_deb_csw (
		.clk(MCLK),
		.rst_n(RST_N),
		.sw(csw_if)
	);
	assign meter_sw_db = msw_if.clean;
	assign cmd_sw_db = csw_if.clean;

	// Per-unit meter-on indication
	genvar gi;
	generate
		for (gi = 0; gi < UNITS; gi++)
		begin : g_unit
			assign unit_meter_on[gi] = UNIT_LOADED[gi] & (~UNIT_AT_MARKER[gi] | UNIT_REWINDING[gi]);
		end
	endgenerate
	assign any_meter_on = |unit_meter_on;

	assign power_on = ctrl_q[umg_pkg::CTRL_PWR_BIT];
	assign busy = ctrl_q[umg_pkg::CTRL_OPBUSY_BIT] | ctrl_q[umg_pkg::CTRL_INTLK_BIT];
	assign change_ok = ~CLOCK_OUT & ~busy;

	// On-line latch
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			online_q <= 1'b0;
		else if (change_ok)
		begin
			if (!cmd_sw_db || !meter_sw_db || !power_on)
				online_q <= 1'b0;
			else
				online_q <= 1'b1;
		end
	end

	assign meter_out_g = METER_OUT & online_q;
	assign RUN_METER = meter_out_g & any_meter_on;
	assign METER_IN = online_q & busy;
	assign IF_ENABLE = online_q;
	assign SELECT_TO_UNIT = SELECT_IN & online_q & cmd_sw_db & meter_sw_db & power_on;
	assign SELECT_BYPASS = SELECT_IN & ~(online_q & cmd_sw_db & meter_sw_db & power_on);

	// Wishbone slave, one wait state
	assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			ack_q <= 1'b0;
		else
			ack_q <= wb_req;
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			ctrl_q <= umg_pkg::CTRL_RESET;
		else if (wb_req && WB_WE_I && WB_ADR_I == umg_pkg::ADDR_CTRL && WB_SEL_I[0])
			ctrl_q <= {29'h0, WB_DAT_I[2:0]};
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			rdat_q <= 32'h0000_0000;
		else if (wb_req && !WB_WE_I)
		begin
			unique case (WB_ADR_I)
				umg_pkg::ADDR_CTRL: rdat_q <= ctrl_q;
				umg_pkg::ADDR_STATUS: rdat_q <= {26'h0, cmd_sw_db, meter_sw_db, METER_IN,
					RUN_METER, busy, online_q};
				umg_pkg::ADDR_UNITS: rdat_q <= {{(32 - UNITS){1'b0}}, unit_meter_on};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// Checks
	property p_run;
		@(posedge MCLK) disable iff (!RST_N)
		RUN_METER |-> (online_q && METER_OUT && any_meter_on);
	endproperty
	a_run: assert property (p_run) else $error("meter runs without cause");

	property p_hold;
		@(posedge MCLK) disable iff (!RST_N)
		(CLOCK_OUT || busy) |=> $stable(online_q);
	endproperty
	a_hold: assert property (p_hold) else $error("on-line changed while locked");

	property p_min;
		@(posedge MCLK) disable iff (!RST_N)
		METER_IN == (online_q && busy);
	endproperty
	a_min: assert property (p_min) else $error("meter-in wrong");

	property p_offline;
		@(posedge MCLK) disable iff (!RST_N)
		!online_q |-> (!RUN_METER && !METER_IN && !IF_ENABLE && !SELECT_TO_UNIT);
	endproperty
	a_offline: assert property (p_offline) else $error("off-line gating failed");

	property p_clear;
		@(posedge MCLK) disable iff (!RST_N)
		(!cmd_sw_db && change_ok) |=> !online_q;
	endproperty
	a_clear: assert property (p_clear) else $error("latch not cleared");

	property p_set;
		@(posedge MCLK) disable iff (!RST_N)
		$rose(online_q) |-> $past(cmd_sw_db && meter_sw_db && change_ok);
	endproperty
	a_set: assert property (p_set) else $error("latch set without both switches");

	property p_bypass;
		@(posedge MCLK) disable iff (!RST_N)
		(SELECT_IN && (!cmd_sw_db || !meter_sw_db || !power_on)) |-> SELECT_BYPASS;
	endproperty
	a_bypass: assert property (p_bypass) else $error("select not bypassed");

	property p_ack;
		@(posedge MCLK) disable iff (!RST_N)
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule : umg_top

// [verif/umg_chan_model.sv]
// Channel side: metering, clock-out and select lines
`timescale 1ns/10ps
module umg_chan_model (
	// Host state
	input wire logic rec,
	input wire logic run,
	input wire logic sel,
	// Channel lines
	output logic meter_out,
	output logic clock_out,
	output logic select_in
);
	assign meter_out = rec;
	assign clock_out = run;
	assign select_in = sel;
endmodule : umg_chan_model

// [verif/testbench.sv]
// Self-checking bench for the usage meter and on-line gating block
`timescale 1ns/10ps
module testbench;
	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, msw = 1'b0, csw = 1'b0;
	logic rec = 1'b0, run = 1'b0, sel = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rd, dq;
	logic [5:0] ld = 6'h00, mk = 6'h00, rw = 6'h00;
	logic ack, mo, co, si, m_in, rm, s_u, s_b, on;
	int miscompares = 0;
	int checked = 0;
	always #2 MCLK = ~MCLK;
	umg_chan_model u_umg_chan_model (.rec(rec), .run(run), .sel(sel),
		.meter_out(mo), .clock_out(co), .select_in(si));
	umg_top #(.DEB_COUNT(4)) u_umg_top (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd),
		.WB_DAT_O(dq), .WB_ACK_O(ack), .METER_SW(msw), .CMD_SW_ONLINE(csw),
		.UNIT_LOADED(ld), .UNIT_AT_MARKER(mk), .UNIT_REWINDING(rw), .METER_OUT(mo),
		.CLOCK_OUT(co), .METER_IN(m_in), .RUN_METER(rm), .SELECT_IN(si),
		.SELECT_TO_UNIT(s_u), .SELECT_BYPASS(s_b), .IF_ENABLE(on));
	task close_out;
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task chk(input logic ok);
		checked++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("wrong value at %0t: output differs", $time);
		end
	endtask : chk
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge MCLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do
		begin
			@(posedge MCLK);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = dq;
		chk(ack === 1'b1);
		if (n == 20) close_out();
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task won(input logic v);
		int n;
		n = 0;
		while (on !== v && n < 20)
		begin
			@(negedge MCLK);
			n++;
		end
		chk(on === v);
		if (n == 20) close_out();
	endtask : won
	task t_reset;
		@(posedge MCLK);
		sel <= 1'b1;
		@(negedge MCLK);
		chk(on === 1'b0 && m_in === 1'b0);
		chk(s_b === 1'b1 && s_u === 1'b0);
	endtask : t_reset
	task t_latch;
		@(posedge MCLK);
		csw <= 1'b1;
		repeat (12) @(posedge MCLK);
		chk(on === 1'b0);
		run <= 1'b1;
		msw <= 1'b1;
		repeat (12) @(posedge MCLK);
		chk(on === 1'b0);
		run <= 1'b0;
		won(1'b1);
		@(negedge MCLK);
		chk(s_u === 1'b1 && s_b === 1'b0);
	endtask : t_latch
	task t_meter;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge MCLK);
			rec <= 1'b1;
			mk <= 6'h00;
			rw <= 6'h00;
			ld <= 6'h01 << i;
			@(negedge MCLK);
			chk(rm === 1'b1);
			@(posedge MCLK);
			mk <= ld;
			@(negedge MCLK);
			chk(rm === 1'b0);
			@(posedge MCLK);
			rw <= ld;
			@(negedge MCLK);
			chk(rm === 1'b1);
		end
		@(posedge MCLK);
		rec <= 1'b0;
		@(negedge MCLK);
		chk(rm === 1'b0);
		@(posedge MCLK);
		rec <= 1'b1;
	endtask : t_meter
	task t_busy;
		chk(m_in === 1'b0);
		wb(1'b1, umg_pkg::ADDR_CTRL, 32'h0000_0005);
		@(negedge MCLK);
		chk(m_in === 1'b1);
		wb(1'b0, umg_pkg::ADDR_STATUS, 32'h0);
		chk(rd[umg_pkg::ST_BUSY_BIT] === 1'b1);
		csw <= 1'b0;
		repeat (12) @(posedge MCLK);
		chk(on === 1'b1);
		wb(1'b1, umg_pkg::ADDR_CTRL, 32'h0000_0006);
		chk(m_in === 1'b1);
		wb(1'b1, umg_pkg::ADDR_CTRL, 32'h0000_0004);
		won(1'b0);
		@(negedge MCLK);
		chk(m_in === 1'b0 && rm === 1'b0 && s_b === 1'b1);
		wb(1'b0, 4'hC, 32'h0);
		chk(rd === 32'h0);
		wb(1'b0, umg_pkg::ADDR_UNITS, 32'h0);
		chk(rd === 32'h0000_0020);
		wb(1'b0, umg_pkg::ADDR_CTRL, 32'h0);
		chk(rd === 32'h0000_0004);
	endtask : t_busy
	initial
	begin
		repeat (16) @(posedge MCLK);
		RST_N <= 1'b1;
		t_reset();
		t_latch();
		t_meter();
		t_busy();
		close_out();
	end
endmodule : testbench
